// file: logic/hsd_pkg.sv
// package: register map, field positions and types for the high-side switch unit
package hsd_pkg;
    localparam int unsigned HSD_CHANNELS = 2;
    // printed offsets are not multiples of four: these are indices, byte address = 4 * index
    localparam logic [2:0] HSD_IDX_DRIVE_DATA = 3'h0;
    localparam logic [2:0] HSD_IDX_DRIVE_CONFIG = 3'h1;
    localparam logic [2:0] HSD_IDX_RESERVED_TWO = 3'h2;
    localparam logic [2:0] HSD_IDX_FACTORY_TEST = 3'h3;
    localparam logic [2:0] HSD_IDX_RESERVED_FOUR = 3'h4;
    localparam logic [2:0] HSD_IDX_RESERVED_FIVE = 3'h5;
    localparam logic [2:0] HSD_IDX_IRQ_CONTROL = 3'h6;
    localparam logic [2:0] HSD_IDX_FLAGS = 3'h7;
    localparam logic [7:0] HSD_ADDR_LIMIT = 8'h1F;
    // field positions
    localparam int unsigned HSD_POS_DATA = 0;
    localparam int unsigned HSD_POS_ENABLE = 0;
    localparam int unsigned HSD_POS_MASK = 4;
    localparam int unsigned HSD_POS_IRQ_EN = 7;
    localparam int unsigned HSD_POS_FLAG = 0;
    // reset values
    localparam logic [1:0] HSD_RST_DATA = 2'h0;
    localparam logic [1:0] HSD_RST_ENABLE = 2'h0;
    localparam logic [1:0] HSD_RST_MASK = 2'h0;
    localparam logic HSD_RST_IRQ_EN = 1'b0;
    localparam logic [1:0] HSD_RST_FLAG = 2'h0;
    // over-current masking window after switch-on
    localparam int unsigned HSD_MASK_WINDOW_NS = 1000;
    localparam int unsigned HSD_CLK_PERIOD_NS = 40;
    localparam logic [7:0] HSD_MASK_CYCLES = 8'(HSD_MASK_WINDOW_NS / HSD_CLK_PERIOD_NS);

    typedef enum logic [1:0] {
        HSD_SRC_DATA = 2'b00,
        HSD_SRC_PWM = 2'b01,
        HSD_SRC_TIMER = 2'b10
    } hsd_src_t;

    typedef enum logic [1:0] {
        HSD_PWR_RUN = 2'b00,
        HSD_PWR_STOP = 2'b01
    } hsd_pwr_t;

    typedef struct packed {
        logic pwm;
        logic timer;
        logic overcurrent;
    } hsd_chan_in_t;
endpackage

// file: logic/hsd_channel.sv
// one switch channel: source selection, over-current mask window and gate drive
`timescale 1ns/1ps
`default_nettype none
module hsd_channel
    import hsd_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire hsd_src_t src_sel,
    input wire hsd_chan_in_t chan_in,
    input wire logic data_bit,
    input wire logic enable,
    input wire logic mask_en,
    input wire logic flag,
    output logic src_value,
    output logic gate_next,
    output logic oc_event
);
    logic [7:0] mask_cnt_reg;
    logic gate_prev_reg;

    // selected control source
    always_comb begin
        case (src_sel)
            HSD_SRC_PWM: src_value = chan_in.pwm; // RQ2
            HSD_SRC_TIMER: src_value = chan_in.timer; // RQ2
            default: src_value = data_bit; // RQ12
        endcase
    end

    // switch is on only when enabled, flag clear and source high
    assign gate_next = enable & ~flag & src_value; // RQ4 RQ16 RQ17

    // mask window counts down from each switch-on edge
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            gate_prev_reg <= 1'b0;
            mask_cnt_reg <= 8'h00;
        end else begin
            gate_prev_reg <= gate_next;
            if (gate_next && !gate_prev_reg && mask_en) begin
                mask_cnt_reg <= HSD_MASK_CYCLES;
            end else if (mask_cnt_reg != 8'h00) begin
                mask_cnt_reg <= mask_cnt_reg - 8'h01;
            end
        end
    end

    assign oc_event = enable & chan_in.overcurrent & (mask_cnt_reg == 8'h00); // RQ3
endmodule
`default_nettype wire

// file: logic/hsd_top.sv
// high-side switch unit: apb register bank, stop-mode handling and two channels
// Contract
// RQ1: two independent switch channels sharing one supply.
// RQ2: each channel driven by its data bit, a pwm or a timer compare output.
// RQ3: over-current while enabled sets a flag and turns the channel off; optional mask.
// RQ4: in run mode the enable bit enables; switch then follows its source.
// RQ5: entering stop disables both channels and turns both switches off.
// RQ6: entering stop clears both software data bits.
// RQ7: leaving stop sets both enable bits automatically.
// RQ8: after stop a data-sourced channel stays off until software writes one.
// RQ9: after stop timer or pwm sources resume; software turns them off beforehand if needed.
// RQ10: with enable 0 the data bit reads back the stored value.
// RQ11: with enable 1 the data bit reads back the selected source value.
// RQ12: data bit 0 turns the switch off, 1 turns it on.
// RQ13: software waits a settling time after enabling before switching on.
// RQ14: eight registers at offsets 0 to 7 above the module base.
// RQ15: unused bits read zero; control bits reset to zero, channels off.
// RQ16: timer or pwm drives the switch only while enabled and flag clear.
// RQ17: a set flag holds the switch off; clearing it returns control.
// RQ18: writing one clears a flag, writing zero leaves it.
// RQ19: mask enable bits are writable only while their channel is disabled.
// RQ20: with interrupt enable set, either flag raises the interrupt request.
`timescale 1ns/1ps
`default_nettype none
module hsd_top
    import hsd_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic stop_req,
    input wire hsd_src_t src_sel_a,
    input wire hsd_src_t src_sel_b,
    input wire hsd_chan_in_t chan_in_a,
    input wire hsd_chan_in_t chan_in_b,
    output logic switch_out_a,
    output logic switch_out_b,
    output logic [1:0] channel_active,
    output logic overcurrent_irq
);
    logic [1:0] switch_data_bit_reg;
    logic [1:0] channel_enable_bit_reg;
    logic [1:0] overcurrent_mask_enable_reg;
    logic overcurrent_irq_enable_reg;
    logic [1:0] overcurrent_flag_reg;
    hsd_pwr_t pwr_reg;
    logic [1:0] stop_sync_reg;
    hsd_chan_in_t [1:0] chan_sync1_reg;
    hsd_chan_in_t [1:0] chan_sync2_reg;
    logic [1:0] src_value;
    logic [1:0] gate_next;
    logic [1:0] oc_event;
    logic wr_en;
    logic rd_en;
    logic bad_addr;
    logic entering_stop;
    logic leaving_stop;
    logic [31:0] rdata_next;
    logic [2:0] reg_idx;

    function automatic logic [31:0] hsd_zext(input logic [7:0] v);
        hsd_zext = {24'h00_0000, v};
    endfunction

    // pins and partner outputs pass two flip-flops
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stop_sync_reg <= 2'b00;
            chan_sync1_reg <= '0;
            chan_sync2_reg <= '0;
        end else begin
            stop_sync_reg <= {stop_sync_reg[0], stop_req};
            chan_sync1_reg <= {chan_in_b, chan_in_a};
            chan_sync2_reg <= chan_sync1_reg;
        end
    end

    // power mode tracking
    assign entering_stop = stop_sync_reg[1] && (pwr_reg == HSD_PWR_RUN);
    assign leaving_stop = !stop_sync_reg[1] && (pwr_reg == HSD_PWR_STOP);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pwr_reg <= HSD_PWR_RUN;
        end else begin
            case (pwr_reg)
                HSD_PWR_RUN: if (entering_stop) pwr_reg <= HSD_PWR_STOP;
                HSD_PWR_STOP: if (leaving_stop) pwr_reg <= HSD_PWR_RUN;
                default: pwr_reg <= HSD_PWR_RUN;
            endcase
        end
    end

    // apb decode, zero wait states
    assign reg_idx = paddr[4:2];
    assign bad_addr = (paddr > HSD_ADDR_LIMIT) || (paddr[1:0] != 2'b00); // RQ14
    assign wr_en = psel && penable && pwrite && !bad_addr;
    assign rd_en = psel && !penable && !pwrite;

    // data register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            switch_data_bit_reg <= HSD_RST_DATA; // RQ15
        end else if (entering_stop) begin
            switch_data_bit_reg <= 2'b00; // RQ6
        end else if (wr_en && reg_idx == HSD_IDX_DRIVE_DATA) begin
            switch_data_bit_reg <= pwdata[HSD_POS_DATA +: 2]; // RQ8
        end
    end

    // enable bits
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            channel_enable_bit_reg <= HSD_RST_ENABLE; // RQ15
        end else if (entering_stop) begin
            channel_enable_bit_reg <= 2'b00; // RQ5
        end else if (leaving_stop) begin
            channel_enable_bit_reg <= 2'b11; // RQ7 RQ9
        end else if (wr_en && reg_idx == HSD_IDX_DRIVE_CONFIG && pwr_reg == HSD_PWR_RUN) begin
            channel_enable_bit_reg <= pwdata[HSD_POS_ENABLE +: 2]; // RQ4
        end
    end

    // mask enables writable per channel only while disabled
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            overcurrent_mask_enable_reg <= HSD_RST_MASK;
        end else if (wr_en && reg_idx == HSD_IDX_DRIVE_CONFIG) begin
            for (int i = 0; i < HSD_CHANNELS; i++) begin
                if (!channel_enable_bit_reg[i]) begin
                    overcurrent_mask_enable_reg[i] <= pwdata[HSD_POS_MASK + i]; // RQ19
                end
            end
        end
    end

    // interrupt enable
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            overcurrent_irq_enable_reg <= HSD_RST_IRQ_EN;
        end else if (wr_en && reg_idx == HSD_IDX_IRQ_CONTROL) begin
            overcurrent_irq_enable_reg <= pwdata[HSD_POS_IRQ_EN];
        end
    end

    // flags: set wins over write-one-to-clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            overcurrent_flag_reg <= HSD_RST_FLAG;
        end else begin
            for (int i = 0; i < HSD_CHANNELS; i++) begin
                if (oc_event[i]) begin
                    overcurrent_flag_reg[i] <= 1'b1; // RQ3
                end else if (wr_en && reg_idx == HSD_IDX_FLAGS && pwdata[HSD_POS_FLAG + i]) begin
                    overcurrent_flag_reg[i] <= 1'b0; // RQ18
                end
            end
        end
    end

    // two independent channels
    for (genvar g = 0; g < HSD_CHANNELS; g++) begin : g_chan
        hsd_channel u_chan (
            .pclk(pclk),
            .presetn(presetn),
            .src_sel(g == 0 ? src_sel_a : src_sel_b),
            .chan_in(chan_sync2_reg[g]),
            .data_bit(switch_data_bit_reg[g]),
            .enable(channel_enable_bit_reg[g]),
            .mask_en(overcurrent_mask_enable_reg[g]),
            .flag(overcurrent_flag_reg[g]),
            .src_value(src_value[g]),
            .gate_next(gate_next[g]),
            .oc_event(oc_event[g])
        ); // RQ1
    end

    // registered outputs
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            switch_out_a <= 1'b0;
            switch_out_b <= 1'b0;
            channel_active <= 2'b00;
            overcurrent_irq <= 1'b0;
        end else begin
            switch_out_a <= gate_next[0]; // RQ17
            switch_out_b <= gate_next[1]; // RQ17
            channel_active <= channel_enable_bit_reg;
            overcurrent_irq <= overcurrent_irq_enable_reg && (overcurrent_flag_reg != 2'b00); // RQ20
        end
    end

    // read mux
    always_comb begin
        rdata_next = 32'h0000_0000;
        case (reg_idx)
            HSD_IDX_DRIVE_DATA: begin
                for (int i = 0; i < HSD_CHANNELS; i++) begin
                    rdata_next[HSD_POS_DATA + i] = channel_enable_bit_reg[i] ? src_value[i] // RQ11
                                                                            : switch_data_bit_reg[i]; // RQ10
                end
            end
            HSD_IDX_DRIVE_CONFIG:
                rdata_next = hsd_zext({2'b00, overcurrent_mask_enable_reg, 2'b00, channel_enable_bit_reg});
            HSD_IDX_IRQ_CONTROL: rdata_next = hsd_zext({overcurrent_irq_enable_reg, 7'h00});
            HSD_IDX_FLAGS: rdata_next = hsd_zext({6'h00, overcurrent_flag_reg});
            default: rdata_next = 32'h0000_0000; // RQ15
        endcase
        if (bad_addr) begin
            rdata_next = 32'h0000_0000;
        end
    end

    // read data latched in setup so it stands through the access phase
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            if (rd_en) begin
                prdata <= rdata_next;
            end
            pready <= psel && !penable;
            pslverr <= psel && !penable && bad_addr;
        end
    end

    a_irq_follows: assert property (@(posedge pclk) disable iff (!presetn)
        (overcurrent_irq_enable_reg && overcurrent_flag_reg != 2'b00) |=> overcurrent_irq) // RQ20
        else $error("irq not raised by flag");
    a_flag_holds_off: assert property (@(posedge pclk) disable iff (!presetn)
        overcurrent_flag_reg[0] |=> !switch_out_a) // RQ17
        else $error("switch a on while flagged");
    a_stop_clears: assert property (@(posedge pclk) disable iff (!presetn)
        entering_stop |=> (switch_data_bit_reg == 2'b00 && channel_enable_bit_reg == 2'b00)) // RQ6
        else $error("stop entry did not clear");
    a_stop_off: assert property (@(posedge pclk) disable iff (!presetn)
        entering_stop |=> ##1 (!switch_out_a && !switch_out_b)) // RQ5
        else $error("switch on after stop entry");
    a_wake_enable: assert property (@(posedge pclk) disable iff (!presetn)
        leaving_stop |=> channel_enable_bit_reg == 2'b11) // RQ7
        else $error("enables not set on wake");
    a_event_sets: assert property (@(posedge pclk) disable iff (!presetn)
        oc_event[1] |=> overcurrent_flag_reg[1] ##1 !switch_out_b) // RQ3
        else $error("over-current did not set flag");
    a_w1c_zero: assert property (@(posedge pclk) disable iff (!presetn)
        (overcurrent_flag_reg[0] && !(wr_en && reg_idx == HSD_IDX_FLAGS && pwdata[0])) |=> overcurrent_flag_reg[0]) // RQ18
        else $error("flag lost without clear");
    a_mask_locked: assert property (@(posedge pclk) disable iff (!presetn)
        channel_enable_bit_reg[1] && !$past(entering_stop) |=> $stable(overcurrent_mask_enable_reg[1]) || !$past(channel_enable_bit_reg[1])) // RQ19
        else $error("mask bit changed while enabled");
    a_disabled_off: assert property (@(posedge pclk) disable iff (!presetn)
        !channel_enable_bit_reg[0] |=> !switch_out_a) // RQ16
        else $error("disabled channel switched on");
    a_data_drives: assert property (@(posedge pclk) disable iff (!presetn)
        (src_sel_a == HSD_SRC_DATA && channel_enable_bit_reg[0] && !overcurrent_flag_reg[0])
        |=> switch_out_a == $past(switch_data_bit_reg[0])) // RQ12
        else $error("data bit not followed");
endmodule
`default_nettype wire

// file: tb/hsd_load_model.sv
// switch stage model: source levels in, over-current back while a shorted load conducts
`timescale 1ns/1ps
`default_nettype none
module hsd_load_model
    import hsd_pkg::*;
(
    input wire logic switch_on,
    input wire logic pwm_level,
    input wire logic timer_level,
    input wire logic shorted,
    output var hsd_chan_in_t chan_in
);
    // current only flows while the switch conducts, so a trip removes its own cause
    assign chan_in = '{pwm: pwm_level, timer: timer_level, overcurrent: switch_on & shorted};
endmodule
`default_nettype wire

// file: tb/test_high_side_driver_control.sv
// testbench: register access, source routing, over-current and stop mode of the switch unit
`timescale 1ns/1ps
`default_nettype none
module test_high_side_driver_control;
    import hsd_pkg::*;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic stop_req = 1'b0;
    hsd_src_t src_sel_a = HSD_SRC_DATA;
    hsd_src_t src_sel_b = HSD_SRC_DATA;
    hsd_chan_in_t chan_in_a;
    hsd_chan_in_t chan_in_b;
    logic switch_out_a;
    logic switch_out_b;
    logic overcurrent_irq;
    logic [1:0] channel_active;
    logic [1:0] pwm_lvl = 2'b00;
    logic [1:0] tim_lvl = 2'b00;
    logic [1:0] short_lvl = 2'b00;
    logic [31:0] rd;
    logic err;
    int n_mismatch = 0;
    int cmp_count = 0;

    always #20 pclk = ~pclk;

    hsd_top i_hsd_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .stop_req(stop_req), .src_sel_a(src_sel_a), .src_sel_b(src_sel_b), .chan_in_a(chan_in_a),
        .chan_in_b(chan_in_b), .switch_out_a(switch_out_a), .switch_out_b(switch_out_b),
        .channel_active(channel_active), .overcurrent_irq(overcurrent_irq));
    hsd_load_model i_hsd_load_model_a (.switch_on(switch_out_a), .pwm_level(pwm_lvl[0]),
        .timer_level(tim_lvl[0]), .shorted(short_lvl[0]), .chan_in(chan_in_a));
    hsd_load_model i_hsd_load_model_b (.switch_on(switch_out_b), .pwm_level(pwm_lvl[1]),
        .timer_level(tim_lvl[1]), .shorted(short_lvl[1]), .chan_in(chan_in_b));

    task chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task results;
        $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // one apb transfer, held until pready is sampled high
    task apb(input logic wr_en, input logic [7:0] addr, input logic [31:0] wd);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr_en;
        paddr <= addr;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        if (n >= 16 && pready !== 1'b1) begin
            n_mismatch++;
            results();
        end else begin
            rd = prdata;
            err = pslverr;
            psel <= 1'b0;
            penable <= 1'b0;
        end
    endtask

    task wr(input logic [2:0] idx, input logic [7:0] val);
        apb(1'b1, {3'b000, idx, 2'b00}, {24'h00_0000, val});
    endtask

    task rdc(input string name, input logic [2:0] idx, input logic [7:0] exp);
        apb(1'b0, {3'b000, idx, 2'b00}, 32'h0000_0000);
        chk(name, rd, {24'h00_0000, exp});
    endtask

    task settle;
        repeat (12) @(posedge pclk);
    endtask

    // packed as irq, active b, active a, switch b, switch a
    task outs(input logic [4:0] exp);
        chk("outputs", {27'h000_0000, overcurrent_irq, channel_active, switch_out_b, switch_out_a}, {27'h000_0000, exp});
    endtask

    initial begin
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        outs(5'b00000);
        rdc("drive_data", HSD_IDX_DRIVE_DATA, 8'h00);
        rdc("drive_config", HSD_IDX_DRIVE_CONFIG, 8'h00);
        rdc("irq_control", HSD_IDX_IRQ_CONTROL, 8'h00);
        rdc("flags", HSD_IDX_FLAGS, 8'h00);
        for (int i = 2; i < 6; i++) begin
            wr(3'(i), 8'hFF);
            rdc("reserved", 3'(i), 8'h00);
        end
        apb(1'b1, 8'h20, 32'h0000_00FF);
        chk("slverr", {31'h0000_0000, err}, 32'h0000_0001);
        wr(HSD_IDX_DRIVE_DATA, 8'hFF);
        rdc("drive_data", HSD_IDX_DRIVE_DATA, 8'h03);
        settle;
        outs(5'b00000);
        wr(HSD_IDX_DRIVE_CONFIG, 8'h01);
        settle;
        outs(5'b00101);
        wr(HSD_IDX_DRIVE_DATA, 8'h00);
        settle;
        outs(5'b00100);
        wr(HSD_IDX_DRIVE_CONFIG, 8'h03);
        src_sel_b <= HSD_SRC_PWM;
        pwm_lvl <= 2'b10;
        settle;
        rdc("drive_data", HSD_IDX_DRIVE_DATA, 8'h02);
        for (int s = 0; s < 3; s++) begin
            for (int l = 0; l < 2; l++) begin
                src_sel_b <= hsd_src_t'(s);
                pwm_lvl[1] <= (s == 1) && (l == 1);
                tim_lvl[1] <= (s == 2) && (l == 1);
                wr(HSD_IDX_DRIVE_DATA, {6'h00, (s == 0) && (l == 1), 1'b0});
                settle;
                outs({3'b011, 1'(l), 1'b0});
            end
        end
        wr(HSD_IDX_DRIVE_CONFIG, 8'h31);
        rdc("drive_config", HSD_IDX_DRIVE_CONFIG, 8'h01);
        wr(HSD_IDX_DRIVE_CONFIG, 8'h00);
        wr(HSD_IDX_DRIVE_CONFIG, 8'h31);
        rdc("drive_config", HSD_IDX_DRIVE_CONFIG, 8'h31);
        wr(HSD_IDX_DRIVE_CONFIG, 8'h01);
        rdc("drive_config", HSD_IDX_DRIVE_CONFIG, 8'h11);
        wr(HSD_IDX_IRQ_CONTROL, 8'hFF);
        rdc("irq_control", HSD_IDX_IRQ_CONTROL, 8'h80);
        wr(HSD_IDX_DRIVE_CONFIG, 8'h13);
        settle;
        tim_lvl[1] <= 1'b1;
        short_lvl[1] <= 1'b1;
        settle;
        outs(5'b11100);
        rdc("flags", HSD_IDX_FLAGS, 8'h02);
        short_lvl[1] <= 1'b0;
        wr(HSD_IDX_FLAGS, 8'h00);
        rdc("flags", HSD_IDX_FLAGS, 8'h02);
        settle;
        outs(5'b11100);
        wr(HSD_IDX_FLAGS, 8'h02);
        rdc("flags", HSD_IDX_FLAGS, 8'h00);
        settle;
        outs(5'b01110);
        wr(HSD_IDX_DRIVE_DATA, 8'h01);
        settle;
        outs(5'b01111);
        // timer source left running across stop on purpose
        stop_req <= 1'b1;
        settle;
        outs(5'b00000);
        rdc("drive_data", HSD_IDX_DRIVE_DATA, 8'h00);
        rdc("drive_config", HSD_IDX_DRIVE_CONFIG, 8'h10);
        stop_req <= 1'b0;
        settle;
        outs(5'b01110);
        wr(HSD_IDX_DRIVE_DATA, 8'h01);
        settle;
        outs(5'b01111);
        // channel a has its mask bit set: a short right at switch-on must not trip before the window ends
        wr(HSD_IDX_DRIVE_DATA, 8'h00);
        settle;
        short_lvl[0] <= 1'b1;
        wr(HSD_IDX_DRIVE_DATA, 8'h01);
        settle;
        outs(5'b01111);
        repeat (20) @(posedge pclk);
        outs(5'b11110);
        rdc("flags", HSD_IDX_FLAGS, 8'h01);
        short_lvl[0] <= 1'b0;
        wr(HSD_IDX_FLAGS, 8'h01);
        rdc("flags", HSD_IDX_FLAGS, 8'h00);
        results();
    end
endmodule
`default_nettype wire
